// ---- pkg/rmsc_pkg.sv ----
// constants and types for the repeater management set-command decoder
package rmsc_pkg;

  // bus register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_OPTIONS = 8'h04;
  localparam logic [7:0] OFS_PORTS   = 8'h08;
  localparam logic [7:0] OFS_LINK    = 8'h0C;

  // command codes and prefixes
  localparam logic [4:0] CMD_OPTIONS_PFX = 5'h01;
  localparam logic [7:0] CMD_AUI_ALT     = 8'h1F;
  localparam logic [7:0] CMD_TP_ALT      = 8'h10;
  localparam logic [7:0] CMD_PRI_AUI_DIS = 8'h2F;
  localparam logic [7:0] CMD_SEC_AUI_DIS = 8'h2E;
  localparam logic [7:0] CMD_PRI_AUI_EN  = 8'h3F;
  localparam logic [7:0] CMD_SEC_AUI_EN  = 8'h3E;
  localparam logic [4:0] CMD_TP_DIS_PFX  = 5'h04;
  localparam logic [4:0] CMD_TP_EN_PFX   = 5'h06;
  localparam logic [4:0] CMD_LT_DIS_PFX  = 5'h08;
  localparam logic [4:0] CMD_LT_EN_PFX   = 5'h0A;
  localparam logic [4:0] CMD_LP_DIS_PFX  = 5'h09;
  localparam logic [4:0] CMD_LP_EN_PFX   = 5'h0B;

  // option bit positions inside the options command
  localparam int OPT_ATTACH = 2;
  localparam int OPT_SQE    = 1;
  localparam int OPT_PAM    = 0;

  // collision test window timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BIT_TIME_PS   = 100000;
  localparam int SQE_OPEN_BITS  = 6;
  localparam int SQE_CLOSE_BITS = 34;
  localparam logic [9:0] SQE_OPEN_CYC = 10'(
    (SQE_OPEN_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [9:0] SQE_CLOSE_CYC = 10'(
    SQE_CLOSE_BITS * BIT_TIME_PS / CLK_PERIOD_PS);

  localparam int SER_BITS = 8;

  typedef struct packed {
    logic       attach;
    logic       sqe_mask;
    logic       alt_pam;
    logic       aui_alt;
    logic       tp_alt;
    logic [1:0] aui_en;
    logic [7:0] tp_en;
    logic [7:0] lt_en;
    logic [7:0] lp_en;
  } rmsc_cfg_t;

  localparam rmsc_cfg_t CFG_RESET = '{
    attach: 1'b0, sqe_mask: 1'b0, alt_pam: 1'b0,
    aui_alt: 1'b0, tp_alt: 1'b0, aui_en: 2'h3,
    tp_en: 8'hFF, lt_en: 8'hFF, lp_en: 8'hFF};

  typedef struct packed {
    logic [1:0] aui;
    logic [7:0] tp;
  } rmsc_ports_t;

endpackage : rmsc_pkg

// ---- src/rmsc_top.sv ----
// set-command decoder, port gating and bus slave of the repeater
////////////////////////////////////////////////////////////////////////////////
module rmsc_top
  import rmsc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial management port
  input  wire logic        mgmt_frame,
  input  wire logic        mgmt_sclk,
  input  wire logic        mgmt_si,
  output logic             mgmt_so,
  output logic             mgmt_so_oe,
  // port status from the repeater core
  input  wire rmsc_ports_t carrier_sense_raw,
  input  wire rmsc_ports_t partitioned,
  input  wire logic [7:0]  tp_link_fail,
  input  wire logic        aui_tx_active,
  input  wire logic        collision_pair_in,
  // configuration and gated signals to the repeater core
  output rmsc_cfg_t        cfg,
  output rmsc_ports_t      part_idle,
  output rmsc_ports_t      carrier_sense,
  output logic [7:0]       tp_disconnect,
  output logic [7:0]       tp_link_ok,
  output logic             aui_collision,
  output logic             aui_collision_report
);

  ////////////////////////////////////////////////////////////////////////////
  // command decoding

  function automatic rmsc_cfg_t apply_cmd(input rmsc_cfg_t c,
                                          input logic      v,
                                          input logic [7:0] k);
    rmsc_cfg_t r;
    r = c;
    if (v) begin
      if (k[7:3] == CMD_OPTIONS_PFX) begin
        r.attach   = k[OPT_ATTACH];
        r.sqe_mask = k[OPT_SQE];
        r.alt_pam  = k[OPT_PAM];
      end
      case (k)
        CMD_AUI_ALT:     r.aui_alt = 1'b1;
        CMD_TP_ALT:      r.tp_alt = 1'b1;
        CMD_PRI_AUI_DIS: r.aui_en[0] = 1'b0;
        CMD_SEC_AUI_DIS: r.aui_en[1] = 1'b0;
        CMD_PRI_AUI_EN:  r.aui_en[0] = 1'b1;
        CMD_SEC_AUI_EN:  r.aui_en[1] = 1'b1;
        default: ;
      endcase
      // port index is the low three bits directly
      case (k[7:3])
        CMD_TP_DIS_PFX: r.tp_en[k[2:0]] = 1'b0;
        CMD_TP_EN_PFX:  r.tp_en[k[2:0]] = 1'b1;
        CMD_LT_DIS_PFX: r.lt_en[k[2:0]] = 1'b0;
        CMD_LT_EN_PFX:  r.lt_en[k[2:0]] = 1'b1;
        CMD_LP_DIS_PFX: r.lp_en[k[2:0]] = 1'b0;
        CMD_LP_EN_PFX:  r.lp_en[k[2:0]] = 1'b1;
        default: ;
      endcase
    end
    return r;
  endfunction : apply_cmd

  function automatic rmsc_ports_t idle_req(input logic      v,
                                           input logic [7:0] k);
    rmsc_ports_t r;
    r = '0;
    if (v) begin
      if (k == CMD_PRI_AUI_DIS) begin
        r.aui[0] = 1'b1;
      end
      if (k == CMD_SEC_AUI_DIS) begin
        r.aui[1] = 1'b1;
      end
      if (k[7:3] == CMD_TP_DIS_PFX) begin
        r.tp[k[2:0]] = 1'b1;
      end
    end
    return r;
  endfunction : idle_req

  ////////////////////////////////////////////////////////////////////////////
  // serial command receiver

  logic [7:0] ser_shift;
  logic [3:0] ser_count;
  logic       sclk_prev;
  logic       ser_valid;
  logic [7:0] ser_cmd;
  logic       sclk_rise;
  logic [7:0] next_ser_shift;

  assign sclk_rise      = mgmt_sclk && !sclk_prev;
  assign next_ser_shift = {mgmt_si, ser_shift[7:1]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= mgmt_sclk;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_shift <= 8'h00;
      ser_count <= 4'h0;
      ser_valid <= 1'b0;
      ser_cmd   <= 8'h00;
    end else begin
      ser_valid <= 1'b0;
      if (!mgmt_frame) begin
        ser_count <= 4'h0;
      end else if (sclk_rise) begin
        ser_shift <= next_ser_shift;
        if (ser_count == 4'(SER_BITS - 1)) begin
          ser_count <= 4'h0;
          ser_cmd   <= next_ser_shift;
          ser_valid <= 1'b1;
        end else begin
          ser_count <= ser_count + 4'h1;
        end
      end
    end
  end

  assign mgmt_so    = 1'b0;
  assign mgmt_so_oe = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  logic       dp_write;
  logic       dp_read;
  logic [7:0] dp_addr;
  logic       bus_valid;
  logic [7:0] bus_cmd;
  logic       ap_take;
  logic [7:0] last_cmd;
  rmsc_cfg_t  next_cfg;
  logic [31:0] next_rdata;

  assign ap_take   = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign bus_valid = dp_write && (dp_addr == OFS_CMD);
  assign bus_cmd   = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= ap_take && hwrite;
      dp_read  <= ap_take && !hwrite;
      if (ap_take) begin
        dp_addr <= haddr[7:0];
      end
    end
  end

  // read data follows the value cfg takes this edge; last_cmd is read as it stands
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CMD:     next_rdata = {24'h00_0000, last_cmd};
      OFS_OPTIONS: next_rdata = {27'h000_0000, next_cfg.tp_alt,
                                 next_cfg.aui_alt, next_cfg.attach,
                                 next_cfg.sqe_mask, next_cfg.alt_pam};
      OFS_PORTS:   next_rdata = {12'h000, partitioned.aui, partitioned.tp,
                                 next_cfg.aui_en, next_cfg.tp_en};
      OFS_LINK:    next_rdata = {8'h00, tp_link_ok, next_cfg.lp_en,
                                 next_cfg.lt_en};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration state

  // bus command applied first, then the serial one, so the serial one wins where both set the same field
  assign next_cfg = apply_cmd(apply_cmd(cfg, bus_valid, bus_cmd),
                              ser_valid, ser_cmd);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      part_idle <= '0;
    end else begin
      part_idle <= idle_req(bus_valid, bus_cmd) | idle_req(ser_valid, ser_cmd);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_cmd <= 8'h00;
    end else if (ser_valid) begin
      last_cmd <= ser_cmd;
    end else if (bus_valid) begin
      last_cmd <= bus_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port gating

  always_comb begin
    if (cfg.alt_pam) begin
      carrier_sense = carrier_sense_raw;
    end else begin
      carrier_sense.tp  = carrier_sense_raw.tp & cfg.tp_en
                          & ~partitioned.tp;
      carrier_sense.aui = carrier_sense_raw.aui & cfg.aui_en
                          & ~partitioned.aui;
    end
  end

  assign tp_disconnect = tp_link_fail & cfg.lt_en;
  assign tp_link_ok    = ~tp_link_fail | ~cfg.lt_en;

  ////////////////////////////////////////////////////////////////////////////
  // collision test window

  logic [9:0] sqe_cnt;
  logic       sqe_window;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sqe_cnt <= 10'h3FF;
    end else if (aui_tx_active) begin
      sqe_cnt <= 10'h000;
    end else if (sqe_cnt != 10'h3FF) begin
      sqe_cnt <= sqe_cnt + 10'h001;
    end
  end

  assign sqe_window = (sqe_cnt >= SQE_OPEN_CYC)
                      && (sqe_cnt <= SQE_CLOSE_CYC);

  assign aui_collision = collision_pair_in && cfg.aui_en[0]
                         && !(cfg.sqe_mask && sqe_window);
  assign aui_collision_report = collision_pair_in && cfg.aui_en[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_serial_quiet: assert property (
    !mgmt_so_oe && !mgmt_so)
    else $error("serial output driven");

  chk_options_load: assert property (
    ser_valid && !bus_valid && ser_cmd[7:3] == CMD_OPTIONS_PFX
    |=> cfg.attach == $past(ser_cmd[2]) && cfg.sqe_mask == $past(ser_cmd[1])
        && cfg.alt_pam == $past(ser_cmd[0]))
    else $error("options not loaded");

  chk_tp_alt_sticky: assert property (
    cfg.tp_alt |=> cfg.tp_alt)
    else $error("tp alternate scheme lost");

  chk_aui_alt_sticky: assert property (
    cfg.aui_alt |=> cfg.aui_alt[*3])
    else $error("aui alternate scheme lost");

  chk_mask_window: assert property (
    cfg.sqe_mask && sqe_window |-> !aui_collision)
    else $error("collision passed inside masked window");

  chk_outside_window: assert property (
    collision_pair_in && cfg.aui_en[0] && !sqe_window |-> aui_collision)
    else $error("collision dropped outside window");

  chk_window_open: assert property (
    $fell(aui_tx_active) |-> !sqe_window[*8])
    else $error("window opened too early");

  chk_report_indep: assert property (
    collision_pair_in && cfg.aui_en[0] |-> aui_collision_report)
    else $error("collision report suppressed");

  chk_crs_masked: assert property (
    !cfg.alt_pam && (|(partitioned.tp & carrier_sense_raw.tp))
    |-> (carrier_sense.tp & partitioned.tp) == 8'h00)
    else $error("carrier sense not masked");

  chk_tp_disable: assert property (
    ser_valid && ser_cmd[7:3] == CMD_TP_DIS_PFX
    |=> !cfg.tp_en[$past(ser_cmd[2:0])] && part_idle.tp[$past(ser_cmd[2:0])]
        ##1 !part_idle.tp[$past(ser_cmd[2:0], 2)])
    else $error("tp disable not applied");

  chk_link_pass: assert property (
    $fell(cfg.lt_en[0]) |-> tp_link_ok[0] && !tp_disconnect[0])
    else $error("link not passing with test off");

  chk_aui_idle: assert property (
    ser_valid && ser_cmd == CMD_PRI_AUI_DIS |=> part_idle.aui[0])
    else $error("aui disable not idling port");

  chk_sec_aui_en: assert property (
    ser_valid && ser_cmd == CMD_SEC_AUI_EN |=> cfg.aui_en[1])
    else $error("secondary aui not enabled");

  chk_lp_disable: assert property (
    ser_valid && ser_cmd[7:3] == CMD_LP_DIS_PFX
    |=> !cfg.lp_en[$past(ser_cmd[2:0])])
    else $error("link pulse not stopped");

  chk_aui_quiet: assert property (
    !cfg.aui_en[0] && !cfg.alt_pam
    |-> !aui_collision && !aui_collision_report && !carrier_sense.aui[0])
    else $error("disabled aui still active");

endmodule : rmsc_top

// ---- tb/rmsc_mgmt_model.sv ----
// serial management controller that shifts set commands into the block
module rmsc_mgmt_model (
  // clock
  input  wire logic hclk,
  // serial management lines
  output logic      mgmt_frame,
  output logic      mgmt_sclk,
  output logic      mgmt_si
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mgmt_frame = 1'b0;
    mgmt_sclk  = 1'b0;
    mgmt_si    = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // shift n bits of a command, then close the frame
  task automatic send(input logic [7:0] cmd, input int n);
    @(posedge hclk) mgmt_frame <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge hclk) mgmt_si <= cmd[i];
      @(posedge hclk) mgmt_sclk <= 1'b1;
      @(posedge hclk) mgmt_sclk <= 1'b0;
    end
    @(posedge hclk) mgmt_frame <= 1'b0;
    mgmt_si <= ~mgmt_si;
  endtask : send
endmodule : rmsc_mgmt_model

// ---- tb/rmsc_top_tb.sv ----
// self-checking bench for the set-command decoder
module rmsc_top_tb import rmsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, rng = 32'hCE13;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp, mgmt_frame, mgmt_sclk, mgmt_si;
  logic        mgmt_so, mgmt_so_oe, aui_tx_active = 1'b0;
  logic        collision_pair_in = 1'b0, aui_collision, aui_collision_report;
  rmsc_ports_t carrier_sense_raw = '0, partitioned = '0;
  rmsc_ports_t part_idle, carrier_sense;
  logic [7:0]  tp_link_fail = '0, tp_disconnect, tp_link_ok, k;
  rmsc_cfg_t   cfg, exp_cfg;
  int          failures = 0, n_compared = 0, cyc = 0, idx;
  localparam logic [36:0] RST_CFG = 37'h003FFFFFF;
  localparam logic [7:0] CODES [13] = '{8'h08, 8'h1F, 8'h10, 8'h2F, 8'h2E,
    8'h3F, 8'h3E, 8'h20, 8'h30, 8'h40, 8'h50, 8'h48, 8'h58};
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  rmsc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mgmt_frame(mgmt_frame),
    .mgmt_sclk(mgmt_sclk), .mgmt_si(mgmt_si), .mgmt_so(mgmt_so),
    .mgmt_so_oe(mgmt_so_oe), .carrier_sense_raw(carrier_sense_raw),
    .partitioned(partitioned), .tp_link_fail(tp_link_fail),
    .aui_tx_active(aui_tx_active), .collision_pair_in(collision_pair_in),
    .cfg(cfg), .part_idle(part_idle), .carrier_sense(carrier_sense),
    .tp_disconnect(tp_disconnect), .tp_link_ok(tp_link_ok),
    .aui_collision(aui_collision),
    .aui_collision_report(aui_collision_report));
  rmsc_mgmt_model mdl_u (.hclk(hclk), .mgmt_frame(mgmt_frame),
    .mgmt_sclk(mgmt_sclk), .mgmt_si(mgmt_si));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift
  function automatic rmsc_cfg_t apply(input rmsc_cfg_t c, input logic [7:0] x);
    case (x)
      8'h1F: c.aui_alt = 1'b1;
      8'h10: c.tp_alt = 1'b1;
      8'h2F: c.aui_en[0] = 1'b0;
      8'h2E: c.aui_en[1] = 1'b0;
      8'h3F: c.aui_en[0] = 1'b1;
      8'h3E: c.aui_en[1] = 1'b1;
      default: case (x[7:3])
        5'h01: {c.attach, c.sqe_mask, c.alt_pam} = x[2:0];
        5'h04: c.tp_en[x[2:0]] = 1'b0;
        5'h06: c.tp_en[x[2:0]] = 1'b1;
        5'h08: c.lt_en[x[2:0]] = 1'b0;
        5'h0A: c.lt_en[x[2:0]] = 1'b1;
        5'h09: c.lp_en[x[2:0]] = 1'b0;
        5'h0B: c.lp_en[x[2:0]] = 1'b1;
        default: ;
      endcase
    endcase
    return c;
  endfunction : apply
  function automatic rmsc_ports_t idle_of(input logic [7:0] x);
    rmsc_ports_t p;
    p = '0;
    if (x == 8'h2F) p.aui[0] = 1'b1;
    if (x == 8'h2E) p.aui[1] = 1'b1;
    if (x[7:3] == 5'h04) p.tp[x[2:0]] = 1'b1;
    return p;
  endfunction : idle_of
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic do_cmd(input logic [7:0] x, input logic via_bus);
    if (via_bus) begin
      ahb(32'h0, 1'b1, {24'h0, x});
      #1;
      check(part_idle, idle_of(x), "idle pulse");
    end else begin
      mdl_u.send(x, 8);
      repeat (3) @(posedge hclk);
      #1;
    end
    exp_cfg = apply(exp_cfg, x);
    check(cfg, exp_cfg, "config");
    check(carrier_sense, exp_cfg.alt_pam ? carrier_sense_raw : carrier_sense_raw
      & {exp_cfg.aui_en, exp_cfg.tp_en} & ~partitioned, "carrier");
    check(tp_disconnect, exp_cfg.lt_en & tp_link_fail, "disc");
    check(tp_link_ok, 8'(~(exp_cfg.lt_en & tp_link_fail)), "link ok");
    check(mgmt_so | mgmt_so_oe, 1'b0, "serial reply");
  endtask : do_cmd
  task automatic sqe_probe(input int n, input logic exp_col);
    @(posedge hclk) aui_tx_active <= 1'b1;
    repeat (5) @(posedge hclk);
    aui_tx_active <= 1'b0;
    repeat (n) @(posedge hclk);
    collision_pair_in <= 1'b1;
    @(posedge hclk);
    #1;
    check(aui_collision, exp_col, "collision mask");
    check(aui_collision_report, 1'b1, "collision report");
    @(posedge hclk) collision_pair_in <= 1'b0;
  endtask : sqe_probe
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    exp_cfg = RST_CFG;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check(cfg, RST_CFG, "reset config");
    mdl_u.send(8'h2F, 4);
    repeat (3) @(posedge hclk);
    check(cfg, RST_CFG, "partial byte");
    do_cmd(8'h2F, 1'b0);
    for (int i = 0; i < 13; i++) begin
      k = CODES[i];
      do_cmd((i == 0 || i > 6) ? k | 8'(i % 8) : k, i[0]);
    end
    for (int i = 0; i < 60; i++) begin
      rng = xorshift(rng);
      @(posedge hclk);
      carrier_sense_raw <= rng[9:0];
      partitioned <= rng[19:10];
      tp_link_fail <= rng[27:20];
      idx = rng[31:28] % 13;
      k = (idx == 0 || idx > 6) ? CODES[idx] | 8'(rng[2:0]) : CODES[idx];
      do_cmd(k, rng[5]);
    end
    ahb(32'h0, 1'b0, 32'h0);
    check(rd[7:0], k, "last command read");
    check({hresp, hreadyout}, 2'b01, "bus response");
    ahb(32'h8, 1'b0, 32'h0);
    check(rd, {12'h000, partitioned, exp_cfg.aui_en, exp_cfg.tp_en},
      "ports read");
    ahb(32'hC, 1'b0, 32'h0);
    check(rd, {8'h00, 8'(~(exp_cfg.lt_en & tp_link_fail)), exp_cfg.lp_en,
      exp_cfg.lt_en}, "link read");
    ahb(32'h4, 1'b0, 32'h0);
    check(rd[4:0], {exp_cfg.tp_alt, exp_cfg.aui_alt, exp_cfg.attach,
      exp_cfg.sqe_mask, exp_cfg.alt_pam}, "options read");
    ahb(32'h40, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped read");
    @(posedge hclk) hresetn <= 1'b0;
    @(posedge hclk) hresetn <= 1'b1;
    #1;
    exp_cfg = RST_CFG;
    check(cfg, RST_CFG, "second reset");
    do_cmd(8'h0A, 1'b1);
    sqe_probe(140, 1'b1);
    sqe_probe(160, 1'b0);
    sqe_probe(840, 1'b0);
    sqe_probe(860, 1'b1);
    do_cmd(8'h08, 1'b1);
    sqe_probe(500, 1'b1);
    do_cmd(8'h2F, 1'b1);
    @(posedge hclk) collision_pair_in <= 1'b1;
    @(posedge hclk);
    #1;
    check({aui_collision, aui_collision_report}, 2'b00, "disabled aui");
    finish_test();
  end
endmodule : rmsc_top_tb
